// ===== t1ec_defs.svh
`ifndef T1EC_DEFS_SVH
`define T1EC_DEFS_SVH

// ----------------------------------------------------------------------
// register addresses on the parallel control port
// ----------------------------------------------------------------------
`define T1EC_ADDR_LINE_HIGH 8'h23
`define T1EC_ADDR_LINE_LOW 8'h24
`define T1EC_ADDR_SHARED_HIGH 8'h25
`define T1EC_ADDR_PATH_LOW 8'h26
`define T1EC_ADDR_MULTIFRAME_LOW 8'h27

// ----------------------------------------------------------------------
// counter widths and field positions
// ----------------------------------------------------------------------
`define T1EC_LINE_WIDTH 16
`define T1EC_PATH_WIDTH 12
`define T1EC_MULTIFRAME_WIDTH 12
`define T1EC_HIGH_NIBBLE_MSB 11
`define T1EC_HIGH_NIBBLE_LSB 8

// ----------------------------------------------------------------------
// zero run lengths and reset values
// ----------------------------------------------------------------------
`define T1EC_ZERO_RUN_PLAIN 5'h10
`define T1EC_ZERO_RUN_B8ZS 5'h08
`define T1EC_READ_RESET 8'h00
`define T1EC_UNMAPPED_READ 8'h00

`endif

// ===== t1ec_pkg.sv
`default_nettype none
`include "t1ec_defs.svh"

package t1ec_pkg;

  // ----------------------------------------------------------------------
  // state of the top level
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] zero_run;
    logic [`T1EC_LINE_WIDTH-1:0] line_snap;
    logic [`T1EC_PATH_WIDTH-1:0] path_snap;
    logic [`T1EC_MULTIFRAME_WIDTH-1:0] multiframe_snap;
    logic [7:0] rd_data;
    logic rd_valid;
  } t1ec_state_type;

endpackage

`default_nettype wire

// ===== t1ec_sat_counter.sv
`default_nettype none

module t1ec_sat_counter #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // control
  input wire logic restart,
  input wire logic [1:0] inc,
  // value
  output logic [WIDTH-1:0] count
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } t1ec_sat_state_type;

  t1ec_sat_state_type state_q;
  t1ec_sat_state_type state_d;
  logic [WIDTH:0] sum;

  // restart drops the old total but keeps this cycle's events
  always_comb begin
    state_d = state_q;
    sum = (restart ? {(WIDTH+1){1'b0}} : {1'b0, state_q.count}) + {{(WIDTH-1){1'b0}}, inc};
    state_d.count = sum[WIDTH] ? {WIDTH{1'b1}} : sum[WIDTH-1:0];
  end

  // plain register of the whole state
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign count = state_q.count;

  // once full, stays full until the next restart
  a_hold_at_max: assert property (@(posedge clock) disable iff (reset)
    (state_q.count == {WIDTH{1'b1}}) && !restart |=> state_q.count == {WIDTH{1'b1}})
    else $error("counter left its maximum without restart");

endmodule

`default_nettype wire

// ===== t1ec_error_counters.sv
// Summary of operation
// - each one second pulse copies totals to readable registers and restarts counting
// - every counter stops at its maximum within a second, never wraps
// - line count is 16 bits, high byte at 0x23, low byte at 0x24
// - with zero suppression on, codeword violations are not counted
// - excess zeros on, suppression off: one count per run of 16 zeros
// - excess zeros on, suppression on: one count per run of 8 zeros
// - line counter keeps counting while sync is lost
// - ESF framing: path counter counts CRC6 errors, Fs option ignored
// - D4 framing: path counter counts Ft errors, plus Fs errors if enabled
// - path counter stops while sync is lost
// - path bits 11..8 in low nibble of 0x25, bits 7..0 at 0x26
// - multiframe bits 11..8 in high nibble of 0x25, bits 7..0 at 0x27
// - mode 1: count multiframes out of sync, only during sync loss
// - mode 0: count Ft (D4) or FPS (ESF) errors, stopped during sync loss
`default_nettype none
`include "t1ec_defs.svh"

module t1ec_error_counters (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // configuration levels
  input wire logic excess_zero_count_enable,
  input wire logic receive_zero_suppression_enable,
  input wire logic receive_framing_select,
  input wire logic fs_error_count_enable,
  input wire logic multiframe_counter_mode_select,
  // receive status and timer
  input wire logic receive_sync_lost,
  input wire logic one_second,
  // line events
  input wire logic bipolar_violation,
  input wire logic violation_in_codeword,
  input wire logic bit_strobe,
  input wire logic bit_is_zero,
  // framing events
  input wire logic crc6_error,
  input wire logic ft_error,
  input wire logic fs_error,
  input wire logic fps_error,
  input wire logic multiframe_boundary,
  // parallel port read
  input wire logic rd_strobe,
  input wire logic [7:0] address,
  output logic [7:0] rd_data,
  output logic rd_valid
);

  // ----------------------------------------------------------------------
  // state and event qualification
  // ----------------------------------------------------------------------
  t1ec_pkg::t1ec_state_type state_q;
  t1ec_pkg::t1ec_state_type state_d;
  logic [`T1EC_LINE_WIDTH-1:0] line_count;
  logic [`T1EC_PATH_WIDTH-1:0] path_count;
  logic [`T1EC_MULTIFRAME_WIDTH-1:0] multiframe_count;
  logic [4:0] zero_limit;
  logic zero_hit;
  logic violation_ok;
  logic [1:0] line_inc;
  logic [1:0] path_inc;
  logic [1:0] multiframe_inc;

  // zero run length depends on the line code in use
  assign zero_limit = receive_zero_suppression_enable ? `T1EC_ZERO_RUN_B8ZS : `T1EC_ZERO_RUN_PLAIN;
  // counted once, on the zero that completes the run; longer runs add nothing more
  assign zero_hit = excess_zero_count_enable && bit_strobe && bit_is_zero &&
                    (state_q.zero_run == zero_limit - 5'h01);
  // deliberate codeword violations only matter when the line code uses them
  assign violation_ok = bipolar_violation && !(receive_zero_suppression_enable && violation_in_codeword);
  // the line counter ignores sync loss on purpose
  assign line_inc = {1'b0, violation_ok} + {1'b0, zero_hit};

  // path counter: CRC6 in ESF, framing bits in D4, frozen without sync
  always_comb begin
    path_inc = 2'h0;
    if (!receive_sync_lost) begin
      if (receive_framing_select) begin
        path_inc = {1'b0, crc6_error};
      end else begin
        path_inc = {1'b0, ft_error} + {1'b0, fs_error && fs_error_count_enable};
      end
    end
  end

  // multiframe counter: out of sync multiframes, or F-bit pattern errors
  always_comb begin
    multiframe_inc = 2'h0;
    if (multiframe_counter_mode_select) begin
      multiframe_inc = {1'b0, multiframe_boundary && receive_sync_lost};
    end else if (!receive_sync_lost) begin
      multiframe_inc = {1'b0, receive_framing_select ? fps_error : ft_error};
    end
  end

  // ----------------------------------------------------------------------
  // accumulating counters
  // ----------------------------------------------------------------------
  t1ec_sat_counter #(.WIDTH(`T1EC_LINE_WIDTH)) u_line_counter (
    .clock(clock),
    .reset(reset),
    .restart(one_second),
    .inc(line_inc),
    .count(line_count)
  );

  t1ec_sat_counter #(.WIDTH(`T1EC_PATH_WIDTH)) u_path_counter (
    .clock(clock),
    .reset(reset),
    .restart(one_second),
    .inc(path_inc),
    .count(path_count)
  );

  t1ec_sat_counter #(.WIDTH(`T1EC_MULTIFRAME_WIDTH)) u_multiframe_counter (
    .clock(clock),
    .reset(reset),
    .restart(one_second),
    .inc(multiframe_inc),
    .count(multiframe_count)
  );

  // ----------------------------------------------------------------------
  // zero run tracking, snapshots and read port
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.rd_valid = 1'b0;
    // run length saturates at the longer limit so it never wraps back into a hit
    if (bit_strobe) begin
      if (!bit_is_zero) begin
        state_d.zero_run = 5'h00;
      end else if (state_q.zero_run != `T1EC_ZERO_RUN_PLAIN) begin
        state_d.zero_run = state_q.zero_run + 5'h01;
      end
    end
    // snapshot holds the completed second; the host has a full second to read
    if (one_second) begin
      state_d.line_snap = line_count;
      state_d.path_snap = path_count;
      state_d.multiframe_snap = multiframe_count;
    end
    // reads see the snapshot as it stood in the request cycle
    if (rd_strobe) begin
      state_d.rd_valid = 1'b1;
      case (address)
        `T1EC_ADDR_LINE_HIGH: begin
          state_d.rd_data = state_q.line_snap[15:8];
        end
        `T1EC_ADDR_LINE_LOW: begin
          state_d.rd_data = state_q.line_snap[7:0];
        end
        `T1EC_ADDR_SHARED_HIGH: begin
          state_d.rd_data = {state_q.multiframe_snap[`T1EC_HIGH_NIBBLE_MSB:`T1EC_HIGH_NIBBLE_LSB],
                             state_q.path_snap[`T1EC_HIGH_NIBBLE_MSB:`T1EC_HIGH_NIBBLE_LSB]};
        end
        `T1EC_ADDR_PATH_LOW: begin
          state_d.rd_data = state_q.path_snap[7:0];
        end
        `T1EC_ADDR_MULTIFRAME_LOW: begin
          state_d.rd_data = state_q.multiframe_snap[7:0];
        end
        default: begin
          state_d.rd_data = `T1EC_UNMAPPED_READ;
        end
      endcase
    end
  end

  // plain register of the whole state
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign rd_data = state_q.rd_data;
  assign rd_valid = state_q.rd_valid;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_read_at(logic [7:0] a);
    rd_strobe && (address == a);
  endsequence

  // plain level, not a sequence, so it can sit inside boolean antecedents
  logic quiet_line;
  assign quiet_line = !one_second && (line_count != 16'hffff);

  a_second_snapshot: assert property (one_second |=> (state_q.line_snap == $past(line_count)) &&
    (state_q.path_snap == $past(path_count)) && (state_q.multiframe_snap == $past(multiframe_count)))
    else $error("snapshot does not match the totals of the second");

  a_line_read: assert property (s_read_at(`T1EC_ADDR_LINE_HIGH) |=> rd_valid &&
    (rd_data == $past(state_q.line_snap[15:8])))
    else $error("line high byte read wrong");

  a_codeword_skip: assert property (violation_in_codeword && receive_zero_suppression_enable &&
    !bit_strobe && quiet_line |=> line_count == $past(line_count))
    else $error("codeword violation was counted");

  a_zero_run_16: assert property (excess_zero_count_enable && !receive_zero_suppression_enable &&
    bit_strobe && bit_is_zero && (state_q.zero_run == 5'h0f) && !bipolar_violation && quiet_line
    |=> line_count == $past(line_count) + 16'h0001)
    else $error("run of sixteen zeros not counted");

  a_zero_run_8: assert property (excess_zero_count_enable && receive_zero_suppression_enable &&
    bit_strobe && bit_is_zero && (state_q.zero_run == 5'h07) && !bipolar_violation && quiet_line
    |=> line_count == $past(line_count) + 16'h0001)
    else $error("run of eight zeros not counted");

  a_line_in_loss: assert property (receive_sync_lost && bipolar_violation && !violation_in_codeword &&
    !bit_strobe && quiet_line |=> line_count == $past(line_count) + 16'h0001)
    else $error("line counter stopped during sync loss");

  a_path_esf: assert property (receive_framing_select && crc6_error && !receive_sync_lost && !one_second &&
    (path_count != 12'hfff) |=> path_count == $past(path_count) + 12'h001)
    else $error("crc6 error not counted");

  a_path_d4: assert property (!receive_framing_select && ft_error && fs_error && fs_error_count_enable &&
    !receive_sync_lost && !one_second && (path_count < 12'hffe) |=> path_count == $past(path_count) + 12'h002)
    else $error("ft and fs errors not both counted");

  a_path_frozen: assert property ((receive_sync_lost && !one_second) [*2] |->
    path_count == $past(path_count))
    else $error("path counter moved during sync loss");

  a_shared_read: assert property (s_read_at(`T1EC_ADDR_SHARED_HIGH) |=>
    rd_data == {$past(state_q.multiframe_snap[11:8]), $past(state_q.path_snap[11:8])})
    else $error("shared high register read wrong");

  a_mf_read: assert property (s_read_at(`T1EC_ADDR_MULTIFRAME_LOW) ##1 1'b1 |->
    rd_data == $past(state_q.multiframe_snap[7:0]))
    else $error("multiframe low byte read wrong");

  a_mos_count: assert property (multiframe_counter_mode_select && receive_sync_lost && multiframe_boundary &&
    !one_second && (multiframe_count != 12'hfff) |=> multiframe_count == $past(multiframe_count) + 12'h001)
    else $error("out of sync multiframe not counted");

  a_fbit_frozen: assert property (!multiframe_counter_mode_select && receive_sync_lost && !one_second
    |=> multiframe_count == $past(multiframe_count))
    else $error("f-bit counter moved during sync loss");

  a_reset_clear: assert property (@(posedge clock) disable iff (1'b0) reset |=>
    (line_count == 16'h0000) && (state_q.line_snap == 16'h0000) && !rd_valid && (rd_data == 8'h00))
    else $error("state not cleared by reset");

endmodule

`default_nettype wire

// ===== t1ec_host.sv
`default_nettype none

module t1ec_host (
  // clock
  input wire logic clock,
  // read port
  output logic rd_strobe,
  output logic [7:0] address,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // host read cycle
  // ----------------------------------------------------------------------
  // strobe for one edge; answer is taken one edge later, once settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clock);
    rd_strobe <= 1'b1;
    address <= a;
    @(posedge clock);
    rd_strobe <= 1'b0;
    address <= ~a; // released address must not look valid
    @(negedge clock);
    v = rd_valid;
    d = rd_data;
  endtask

  // idle bus at time zero
  initial begin
    rd_strobe = 1'b0;
    address = 8'h00;
  end
endmodule

`default_nettype wire

// ===== t1ec_error_counters_tb.sv
`default_nettype none

module t1ec_error_counters_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic clock, reset, one_second, rd_strobe, rd_valid;
  logic [7:0] address, rd_data, d;
  logic [5:0] cfg; // zero count, suppression, esf, fs count, mode, sync lost
  logic [8:0] ev;
  logic [15:0] l;
  logic [11:0] p, m;
  logic v;
  int errors, checks, cycles, seed, n, k, e;
  int c [9];

  t1ec_error_counters i_t1ec_error_counters (
    .clock(clock), .reset(reset),
    .excess_zero_count_enable(cfg[5]), .receive_zero_suppression_enable(cfg[4]),
    .receive_framing_select(cfg[3]), .fs_error_count_enable(cfg[2]),
    .multiframe_counter_mode_select(cfg[1]), .receive_sync_lost(cfg[0]),
    .one_second(one_second), .bipolar_violation(ev[0]), .violation_in_codeword(ev[1]),
    .bit_strobe(ev[2]), .bit_is_zero(ev[3]), .crc6_error(ev[4]), .ft_error(ev[5]),
    .fs_error(ev[6]), .fps_error(ev[7]), .multiframe_boundary(ev[8]),
    .rd_strobe(rd_strobe), .address(address), .rd_data(rd_data), .rd_valid(rd_valid)
  );

  t1ec_host i_t1ec_host (
    .clock(clock), .rd_strobe(rd_strobe), .address(address), .rd_data(rd_data), .rd_valid(rd_valid)
  );

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] x, input logic [15:0] g);
    checks++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, x, g);
    end
  endtask

  // saturating expectation for a w-bit counter
  function automatic logic [15:0] sat(input int x, input int w);
    return 16'((x > (1 << w) - 1) ? (1 << w) - 1 : x);
  endfunction

  // events held high for cnt back-to-back edges
  task automatic hold(input logic [8:0] x, input int cnt);
    @(posedge clock);
    ev <= x;
    repeat (cnt) @(posedge clock);
    ev <= '0;
  endtask

  // second boundary, then read all five registers
  task automatic sec();
    logic [7:0] r [5];
    @(posedge clock);
    one_second <= 1'b1;
    @(posedge clock);
    one_second <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      i_t1ec_host.rd(8'h23 + 8'(i), r[i], v);
      chk("rd_valid", 16'h0001, {15'h0000, v});
    end
    l = {r[0], r[1]};
    p = {r[2][3:0], r[3]};
    m = {r[2][7:4], r[4]};
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // full-scale line saturation dominates the run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      results();
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    seed = 32'h22f7;
    reset = 1'b1;
    one_second = 1'b0;
    cfg = '0;
    ev = '0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    sec();
    chk("line", 16'h0000, l);
    chk("shared", 16'h0000, {p, m[11:8]});
    i_t1ec_host.rd(8'h28, d, v);
    chk("unmapped", 16'h0000, {8'h00, d});
    $display("test reset done");
    // codeword violations dropped only under suppression, sync lost throughout
    for (int s = 0; s < 2; s++) begin
      @(posedge clock);
      cfg <= {1'b0, s[0], 4'b0001};
      n = ($random(seed) & 15) + 1;
      k = ($random(seed) & 15) + 1;
      hold(9'h001, n);
      hold(9'h003, k);
      sec();
      chk("line", sat(s ? n : n + k, 16), l);
    end
    $display("test violations done");
    // a one, 17 zeros, a one, 8 zeros: short run counts only with suppression
    // the leading one ends the run left over from the pass before
    for (int s = 0; s < 2; s++) begin
      @(posedge clock);
      cfg <= {1'b1, s[0], 4'b0000};
      hold(9'h004, 1);
      hold(9'h00c, 17);
      hold(9'h004, 1);
      hold(9'h00c, 8);
      sec();
      chk("zero runs", s ? 16'h0002 : 16'h0001, l);
    end
    $display("test zero runs done");
    // every framing, fs option, mode and sync combination
    for (int i = 0; i < 16; i++) begin
      @(posedge clock);
      cfg <= {2'b00, i[0], i[1], i[2], i[3]};
      for (int j = 4; j < 9; j++) begin
        c[j] = ($random(seed) & 7) + 1;
        hold(9'(1 << j), c[j]);
      end
      sec();
      e = i[3] ? 0 : i[0] ? c[4] : c[5] + (i[1] ? c[6] : 0);
      chk("path", 16'(e), {4'h0, p});
      e = i[2] ? (i[3] ? c[8] : 0) : (i[3] ? 0 : i[0] ? c[7] : c[5]);
      chk("multiframe", 16'(e), {4'h0, m});
    end
    $display("test framing done");
    @(posedge clock);
    // D4 with fs counting: ft and fs in one cycle add two to the path count
    cfg <= 6'b000100;
    hold(9'h061, 65540);
    sec();
    chk("line sat", 16'hffff, l);
    chk("path sat", 16'h0fff, {4'h0, p});
    chk("multiframe sat", 16'h0fff, {4'h0, m});
    sec();
    chk("restart", 16'h0000, l);
    $display("test saturation done");
    results();
  end
endmodule

`default_nettype wire
